// File: logic/aocr_regs.svh
// Register offsets, field positions, reset values and limits of the offset compensation register bank
`ifndef AOCR_REGS_SVH
`define AOCR_REGS_SVH

`define AOCR_ADDR_ID 8'h00
`define AOCR_ADDR_X_LOW 8'h02
`define AOCR_ADDR_X_HIGH 8'h03
`define AOCR_ADDR_Y_LOW 8'h04
`define AOCR_ADDR_Y_HIGH 8'h05
`define AOCR_ADDR_Z_LOW 8'h06
`define AOCR_ADDR_Z_HIGH 8'h07
`define AOCR_ADDR_FLAGS 8'h0a
`define AOCR_ADDR_RANGE 8'h0f
`define AOCR_ADDR_BW 8'h10
`define AOCR_ADDR_POWER 8'h11
`define AOCR_ADDR_SETUP 8'h13
`define AOCR_ADDR_SOFT_RESET 8'h14
`define AOCR_ADDR_EN 8'h17
`define AOCR_ADDR_MAP 8'h1a
`define AOCR_ADDR_SRC 8'h1e
`define AOCR_ADDR_PINCFG 8'h20
`define AOCR_ADDR_SERIAL 8'h34
`define AOCR_ADDR_OFS_CTRL 8'h36
`define AOCR_ADDR_OFS_X 8'h38
`define AOCR_ADDR_OFS_Y 8'h39
`define AOCR_ADDR_OFS_Z 8'h3a

`define AOCR_RST_RANGE 4'h3
`define AOCR_RST_BW 5'h1f
`define AOCR_RST_LV 1'b1

`define AOCR_RANGE_CODE_2G 4'h3
`define AOCR_RANGE_CODE_4G 4'h5
`define AOCR_RANGE_CODE_8G 4'h8

`define AOCR_BIT_NEW 0
`define AOCR_BIT_FRESH 7
`define AOCR_BIT_SUSPEND 7
`define AOCR_BIT_DATA_SEL 7
`define AOCR_BIT_PROTECT_DIS 6
`define AOCR_BIT_DATA_EN 4
`define AOCR_BIT_MAP 0
`define AOCR_BIT_SRC 5
`define AOCR_BIT_OD 1
`define AOCR_BIT_LV 0
`define AOCR_BIT_WDT_EN 2
`define AOCR_BIT_WDT_SEL 1
`define AOCR_BIT_OFS_CLEAR 7

`define AOCR_SAT_MAX 12'sh1ff
`define AOCR_SAT_MIN 12'she00

`endif

// File: logic/aocr_pkg.sv
// Types shared by the offset compensation register bank
package aocr_pkg;
    typedef logic signed [9:0] aocr_sample_t;
    typedef logic signed [7:0] aocr_offset_t;
    typedef enum logic [2:0] {
        AOCR_SCALE_2G = 3'b001,
        AOCR_SCALE_4G = 3'b010,
        AOCR_SCALE_8G = 3'b100
    } aocr_scale_t;
endpackage

// File: logic/aocr_core.sv
// Offset compensation datapath and register bank of a 3-axis accelerometer
//
// Behaviour
// - Each axis output is the raw sample plus that axis offset, before storing.
// - Three 8-bit two's complement offset registers at 0x38, 0x39, 0x3a.
// - One offset step weighs 7.81 mg in every range; scaled to output resolution.
// - Writing one to the clear bit at 0x36 zeroes all three offsets.
// - Samples are signed 10-bit: high bits in high register, low bits in low.
// - Range codes 0011, 0101, 1000 give 2g, 4g, 8g; other codes scale as 2g.
// - Enabled new data sets the fresh sample flag and drives the mapped pin.
`timescale 1ns/1ps
`include "aocr_regs.svh"

module aocr_core import aocr_pkg::*; #(
    // Identifier value is arbitrary
    parameter logic [7:0] DEVICE_ID = 8'h42,
    parameter logic [7:0] SOFT_RESET_KEY = 8'h5a
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register access from the serial engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Filtered sample stream
    input wire logic filt_valid,
    input wire logic [9:0] filt_x,
    input wire logic [9:0] filt_y,
    input wire logic [9:0] filt_z,
    // Unfiltered sample stream
    input wire logic unfilt_valid,
    input wire logic [9:0] unfilt_x,
    input wire logic [9:0] unfilt_y,
    input wire logic [9:0] unfilt_z,
    // Event pin, output enable low while driving
    output logic event_pin_o,
    output logic event_pin_oe_n,
    // Settings for neighbouring blocks
    output logic [4:0] filter_width,
    output logic wdt_en,
    output logic wdt_sel
);

    function automatic aocr_scale_t range_decode(input logic [3:0] code);
        case (code)
            `AOCR_RANGE_CODE_2G: range_decode = AOCR_SCALE_2G;
            `AOCR_RANGE_CODE_4G: range_decode = AOCR_SCALE_4G;
            `AOCR_RANGE_CODE_8G: range_decode = AOCR_SCALE_8G;
            default: range_decode = AOCR_SCALE_2G;
        endcase
    endfunction

    function automatic aocr_sample_t compensate(input aocr_sample_t smp, input aocr_offset_t ofs,
                                                input aocr_scale_t sc);
        logic signed [11:0] adj;
        logic signed [11:0] sum;
        adj = 12'sh000;
        unique case (sc)
            AOCR_SCALE_2G: adj = {{3{ofs[7]}}, ofs, 1'b0};
            AOCR_SCALE_4G: adj = {{4{ofs[7]}}, ofs};
            AOCR_SCALE_8G: adj = {{5{ofs[7]}}, ofs[7:1]};
        endcase
        sum = {{2{smp[9]}}, smp} + adj;
        if (sum > `AOCR_SAT_MAX) begin
            sum = `AOCR_SAT_MAX;
        end else if (sum < `AOCR_SAT_MIN) begin
            sum = `AOCR_SAT_MIN;
        end
        compensate = sum[9:0];
    endfunction

    logic [3:0] range_ff;
    logic [4:0] bw_ff;
    logic suspend_ff;
    logic data_sel_ff;
    logic protect_dis_ff;
    logic data_en_ff;
    logic map_ff;
    logic src_ff;
    logic od_ff;
    logic lv_ff;
    logic wdt_en_ff;
    logic wdt_sel_ff;
    aocr_offset_t ofs_ff [3];
    aocr_sample_t out_ff [3];
    logic [7:0] msb_ff [3];
    logic [2:0] new_ff;
    logic fresh_ff;
    logic [7:0] rdata_ff;
    logic pin_ff;
    logic pin_oe_n_ff;

    // Access decode; in suspend only power and soft reset writes land
    wire logic wr_ok = reg_wr & (~suspend_ff | reg_addr == `AOCR_ADDR_POWER | reg_addr == `AOCR_ADDR_SOFT_RESET);
    wire logic soft_rst = wr_ok & reg_addr == `AOCR_ADDR_SOFT_RESET & reg_wdata == SOFT_RESET_KEY;
    wire logic ofs_clear = wr_ok & reg_addr == `AOCR_ADDR_OFS_CTRL & reg_wdata[`AOCR_BIT_OFS_CLEAR];
    wire logic rd_flags = reg_rd & reg_addr == `AOCR_ADDR_FLAGS;
    wire aocr_scale_t scale = range_decode(range_ff);

    // Sample selection and compensation
    wire aocr_sample_t filt_s [3] = '{filt_x, filt_y, filt_z};
    wire aocr_sample_t unfilt_s [3] = '{unfilt_x, unfilt_y, unfilt_z};
    wire logic samp_vld = ~suspend_ff & (data_sel_ff ? unfilt_valid : filt_valid);
    wire logic event_vld = ~suspend_ff & (src_ff ? unfilt_valid : filt_valid);
    wire logic fresh_set = event_vld & data_en_ff;
    aocr_sample_t comp [3];
    logic [2:0] rd_low;
    logic [2:0] rd_high;
    logic [2:0] wr_ofs;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            comp[i] = compensate(data_sel_ff ? unfilt_s[i] : filt_s[i], ofs_ff[i], scale);
            rd_low[i] = reg_rd & reg_addr == 8'(`AOCR_ADDR_X_LOW + 2 * i);
            rd_high[i] = reg_rd & reg_addr == 8'(`AOCR_ADDR_X_HIGH + 2 * i);
            wr_ofs[i] = wr_ok & reg_addr == 8'(`AOCR_ADDR_OFS_X + i);
        end
    end

    // Configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            range_ff <= `AOCR_RST_RANGE;
            bw_ff <= `AOCR_RST_BW;
            {suspend_ff, data_sel_ff, protect_dis_ff, data_en_ff, map_ff, src_ff} <= 6'h00;
            {od_ff, wdt_en_ff, wdt_sel_ff} <= 3'h0;
            lv_ff <= `AOCR_RST_LV;
        end else if (soft_rst) begin
            range_ff <= `AOCR_RST_RANGE;
            bw_ff <= `AOCR_RST_BW;
            {suspend_ff, data_sel_ff, protect_dis_ff, data_en_ff, map_ff, src_ff} <= 6'h00;
            {od_ff, wdt_en_ff, wdt_sel_ff} <= 3'h0;
            lv_ff <= `AOCR_RST_LV;
        end else if (wr_ok) begin
            case (reg_addr)
                `AOCR_ADDR_RANGE: range_ff <= reg_wdata[3:0];
                `AOCR_ADDR_BW: bw_ff <= reg_wdata[4:0];
                `AOCR_ADDR_POWER: suspend_ff <= reg_wdata[`AOCR_BIT_SUSPEND];
                `AOCR_ADDR_SETUP: begin
                    data_sel_ff <= reg_wdata[`AOCR_BIT_DATA_SEL];
                    protect_dis_ff <= reg_wdata[`AOCR_BIT_PROTECT_DIS];
                end
                `AOCR_ADDR_EN: data_en_ff <= reg_wdata[`AOCR_BIT_DATA_EN];
                `AOCR_ADDR_MAP: map_ff <= reg_wdata[`AOCR_BIT_MAP];
                `AOCR_ADDR_SRC: src_ff <= reg_wdata[`AOCR_BIT_SRC];
                `AOCR_ADDR_PINCFG: begin
                    od_ff <= reg_wdata[`AOCR_BIT_OD];
                    lv_ff <= reg_wdata[`AOCR_BIT_LV];
                end
                `AOCR_ADDR_SERIAL: begin
                    wdt_en_ff <= reg_wdata[`AOCR_BIT_WDT_EN];
                    wdt_sel_ff <= reg_wdata[`AOCR_BIT_WDT_SEL];
                end
                default: ;
            endcase
        end
    end

    // Offsets; clear wins over a write in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ofs_ff <= '{8'h00, 8'h00, 8'h00};
        end else if (soft_rst || ofs_clear) begin
            ofs_ff <= '{8'h00, 8'h00, 8'h00};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_ofs[i]) begin
                    ofs_ff[i] <= reg_wdata;
                end
            end
        end
    end

    // Output registers with data protection and new-data flags
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ff <= '{10'h000, 10'h000, 10'h000};
            msb_ff <= '{8'h00, 8'h00, 8'h00};
            new_ff <= 3'h0;
        end else if (soft_rst) begin
            out_ff <= '{10'h000, 10'h000, 10'h000};
            msb_ff <= '{8'h00, 8'h00, 8'h00};
            new_ff <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (samp_vld) begin
                    out_ff[i] <= comp[i];
                end
                if (samp_vld && protect_dis_ff) begin
                    msb_ff[i] <= comp[i][9:2];
                end else if (rd_low[i] && !protect_dis_ff) begin
                    msb_ff[i] <= out_ff[i][9:2];
                end
                if (samp_vld) begin
                    new_ff[i] <= 1'b1;
                end else if (rd_low[i] || rd_high[i]) begin
                    new_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Fresh sample flag and event pin; set wins over read clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fresh_ff <= 1'b0;
            pin_ff <= 1'b0;
            pin_oe_n_ff <= 1'b0;
        end else begin
            fresh_ff <= soft_rst ? 1'b0 : fresh_set ? 1'b1 : rd_flags ? 1'b0 : fresh_ff;
            pin_ff <= lv_ff ~^ (fresh_ff & map_ff);
            pin_oe_n_ff <= od_ff & ~(fresh_ff & map_ff);
        end
    end

    // Read data selection; reserved and write-only bits read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `AOCR_ADDR_ID: rd_mux = DEVICE_ID;
            `AOCR_ADDR_X_LOW: rd_mux = {out_ff[0][1:0], 5'h00, new_ff[0]};
            `AOCR_ADDR_X_HIGH: rd_mux = msb_ff[0];
            `AOCR_ADDR_Y_LOW: rd_mux = {out_ff[1][1:0], 5'h00, new_ff[1]};
            `AOCR_ADDR_Y_HIGH: rd_mux = msb_ff[1];
            `AOCR_ADDR_Z_LOW: rd_mux = {out_ff[2][1:0], 5'h00, new_ff[2]};
            `AOCR_ADDR_Z_HIGH: rd_mux = msb_ff[2];
            `AOCR_ADDR_FLAGS: rd_mux = {fresh_ff, 7'h00};
            `AOCR_ADDR_RANGE: rd_mux = {4'h0, range_ff};
            `AOCR_ADDR_BW: rd_mux = {3'h0, bw_ff};
            `AOCR_ADDR_POWER: rd_mux = {suspend_ff, 7'h00};
            `AOCR_ADDR_SETUP: rd_mux = {data_sel_ff, protect_dis_ff, 6'h00};
            `AOCR_ADDR_EN: rd_mux = {3'h0, data_en_ff, 4'h0};
            `AOCR_ADDR_MAP: rd_mux = {7'h00, map_ff};
            `AOCR_ADDR_SRC: rd_mux = {2'h0, src_ff, 5'h00};
            `AOCR_ADDR_PINCFG: rd_mux = {6'h00, od_ff, lv_ff};
            `AOCR_ADDR_SERIAL: rd_mux = {5'h00, wdt_en_ff, wdt_sel_ff, 1'b0};
            `AOCR_ADDR_OFS_X: rd_mux = ofs_ff[0];
            `AOCR_ADDR_OFS_Y: rd_mux = ofs_ff[1];
            `AOCR_ADDR_OFS_Z: rd_mux = ofs_ff[2];
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end
    end

    assign reg_rdata = rdata_ff;
    assign event_pin_o = pin_ff;
    assign event_pin_oe_n = pin_oe_n_ff;
    assign filter_width = bw_ff;
    assign wdt_en = wdt_en_ff;
    assign wdt_sel = wdt_sel_ff;

    property p_x_compensated;
        @(posedge ref_clk) disable iff (!rst_n)
        samp_vld && !soft_rst |=> out_ff[0] == $past(comp[0]);
    endproperty
    a_x_compensated: assert property (p_x_compensated) else $error("x output not the compensated sum");

    property p_ofs_write_read;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_ok && reg_addr == `AOCR_ADDR_OFS_Y && !ofs_clear && !soft_rst ##1 !reg_wr
        ##1 reg_rd && reg_addr == `AOCR_ADDR_OFS_Y
        |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_ofs_write_read: assert property (p_ofs_write_read) else $error("y offset did not read back");

    property p_scale_4g;
        @(posedge ref_clk) disable iff (!rst_n)
        range_ff == `AOCR_RANGE_CODE_4G && data_sel_ff == 1'b0 && filt_x == 10'h000 && !ofs_ff[0][7]
        |-> comp[0] == {2'h0, ofs_ff[0]};
    endproperty
    a_scale_4g: assert property (p_scale_4g) else $error("offset not unscaled in 4g range");

    property p_ofs_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        ofs_clear |=> ofs_ff[0] == 8'h00 && ofs_ff[1] == 8'h00 && ofs_ff[2] == 8'h00;
    endproperty
    a_ofs_clear: assert property (p_ofs_clear) else $error("offsets not cleared");

    property p_low_read;
        @(posedge ref_clk) disable iff (!rst_n)
        rd_low[0] |=> reg_rdata[7:6] == $past(out_ff[0][1:0]) && reg_rdata[5:1] == 5'h00;
    endproperty
    a_low_read: assert property (p_low_read) else $error("x low register layout wrong");

    property p_scale_8g;
        @(posedge ref_clk) disable iff (!rst_n)
        range_ff == `AOCR_RANGE_CODE_8G && data_sel_ff == 1'b0 && filt_x == 10'h000 && !ofs_ff[0][7]
        |-> comp[0] == {3'h0, ofs_ff[0][7:1]};
    endproperty
    a_scale_8g: assert property (p_scale_8g) else $error("offset not halved in 8g range");

    property p_fresh_pin;
        @(posedge ref_clk) disable iff (!rst_n)
        fresh_set && !soft_rst && map_ff && lv_ff ##1 map_ff && lv_ff |-> fresh_ff ##1 event_pin_o;
    endproperty
    a_fresh_pin: assert property (p_fresh_pin) else $error("fresh sample did not reach the pin");

    property p_no_wrap;
        @(posedge ref_clk) disable iff (!rst_n)
        samp_vld && !soft_rst && !data_sel_ff && !filt_x[9] && !ofs_ff[0][7] |=> !out_ff[0][9];
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("positive sum wrapped negative");

endmodule

// File: testbench/aocr_host_model.sv
// Register host model that issues single-cycle read and write strobes
`timescale 1ns/1ps

module aocr_host_model (
    // Clock
    input wire logic ref_clk,
    // Register strobes toward the device
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    // Read data from the device
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'hff;
        reg_wdata = 8'hff;
    end

    // Released address and data are inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

// File: testbench/test_accel_offset_comp_register_map.sv
// Self-checking testbench of the offset compensation register bank
`timescale 1ns/1ps

module test_accel_offset_comp_register_map import aocr_pkg::*;;
    localparam logic [7:0] ID_VAL = 8'h42;
    logic ref_clk;
    logic rst_n;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic filt_valid;
    logic unfilt_valid;
    logic [9:0] filt_x, filt_y, filt_z, unfilt_x, unfilt_y, unfilt_z;
    logic event_pin_o;
    logic event_pin_oe_n;
    logic [4:0] filter_width;
    logic wdt_en;
    logic wdt_sel;
    int compares = 0;
    int miscompares = 0;

    aocr_core #(.DEVICE_ID(ID_VAL)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .filt_valid(filt_valid), .filt_x(filt_x),
        .filt_y(filt_y), .filt_z(filt_z), .unfilt_valid(unfilt_valid), .unfilt_x(unfilt_x),
        .unfilt_y(unfilt_y), .unfilt_z(unfilt_z), .event_pin_o(event_pin_o), .event_pin_oe_n(event_pin_oe_n),
        .filter_width(filter_width), .wdt_en(wdt_en), .wdt_sel(wdt_sel)
    );

    aocr_host_model u_host (
        .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: pin got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        check_byte(d, exp);
    endtask

    // One sample on the chosen stream; released data is inverted
    task automatic sample(input logic sel, input logic [9:0] x, input logic [9:0] y, input logic [9:0] z);
        @(negedge ref_clk);
        {filt_x, filt_y, filt_z, unfilt_x, unfilt_y, unfilt_z} = {x, y, z, x, y, z};
        filt_valid = ~sel;
        unfilt_valid = sel;
        @(negedge ref_clk);
        filt_valid = 1'b0;
        unfilt_valid = 1'b0;
        {filt_x, filt_y, filt_z, unfilt_x, unfilt_y, unfilt_z} = ~{x, y, z, x, y, z};
    endtask

    // Offset scaled to the range resolution, added and clamped to ten bits
    function automatic logic [9:0] exp_out(logic [9:0] raw, logic [7:0] ofs, logic [3:0] rng);
        int s;
        int o;
        s = $signed(raw);
        o = $signed(ofs);
        case (rng)
            4'h5: s = s + o;
            4'h8: s = s + (o >>> 1);
            default: s = s + 2 * o;
        endcase
        if (s > 511) s = 511;
        if (s < -512) s = -512;
        return s[9:0];
    endfunction

    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end

    initial begin
        logic [7:0] ra [8];
        logic [7:0] rv [8];
        logic [3:0] codes [3];
        logic [3:0] rng;
        logic [7:0] o [3];
        logic [9:0] r [3];
        logic [9:0] e;
        logic sel;
        ra = '{8'h00, 8'h0f, 8'h10, 8'h20, 8'h38, 8'h39, 8'h3a, 8'h01};
        rv = '{ID_VAL, 8'h03, 8'h1f, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        codes = '{4'h3, 4'h5, 4'h8};
        rst_n = 1'b0;
        filt_valid = 1'b0;
        unfilt_valid = 1'b0;
        {filt_x, filt_y, filt_z, unfilt_x, unfilt_y, unfilt_z} = '0;
        repeat (10) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        void'($urandom(32'hf68d));
        for (int k = 0; k < 8; k++) rdc(ra[k], rv[k]);
        check_byte({3'h0, filter_width}, 8'h1f);
        for (int k = 0; k < 3; k++) begin
            u_host.wr(8'h38 + k[7:0], 8'h80 + k[7:0]);
            rdc(8'h38 + k[7:0], 8'h80 + k[7:0]);
        end
        u_host.wr(8'h36, 8'h80);
        for (int k = 0; k < 3; k++) rdc(8'h38 + k[7:0], 8'h00);
        rdc(8'h36, 8'h00);
        for (int i = 0; i < 40; i++) begin
            rng = codes[$urandom % 3];
            sel = 1'($urandom);
            for (int k = 0; k < 3; k++) begin
                o[k] = 8'($urandom);
                r[k] = 10'($urandom);
            end
            if (i < 3) begin
                rng = codes[i];
            end
            if (i == 1) begin
                o = '{8'h80, 8'h80, 8'h80};
                r = '{10'h200, 10'h200, 10'h201};
            end else if (i < 3) begin
                o = '{8'h7f, 8'h01, 8'h7f};
                r = '{10'h1ff, 10'h1ff, 10'h1fe};
            end else if (i < 5) begin
                // Zero input so the unscaled and halved offsets show alone
                rng = codes[i - 2];
                sel = 1'b0;
                o = '{8'h35, 8'hc1, 8'h7f};
                r = '{10'h000, 10'h000, 10'h000};
            end
            u_host.wr(8'h0f, {4'h0, rng});
            u_host.wr(8'h13, {sel, 7'h00});
            for (int k = 0; k < 3; k++) u_host.wr(8'h38 + k[7:0], o[k]);
            sample(sel, r[0], r[1], r[2]);
            for (int k = 0; k < 3; k++) begin
                e = exp_out(r[k], o[k], rng);
                rdc(8'h02 + 8'(2 * k), {e[1:0], 5'h00, 1'b1});
                rdc(8'h03 + 8'(2 * k), e[9:2]);
            end
        end
        u_host.wr(8'h17, 8'h10);
        u_host.wr(8'h1a, 8'h01);
        sample(1'b0, 10'h011, 10'h022, 10'h033);
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        check_bit(event_pin_o, 1'b1);
        check_bit(event_pin_oe_n, 1'b0);
        rdc(8'h0a, 8'h80);
        @(posedge ref_clk);
        #1;
        check_bit(event_pin_o, 1'b0);
        u_host.wr(8'h34, 8'h06);
        check_bit(wdt_en, 1'b1);
        check_bit(wdt_sel, 1'b1);
        // Protection off, event from unfiltered stream, open-drain active-low pin
        u_host.wr(8'h13, 8'h40);
        u_host.wr(8'h1e, 8'h20);
        u_host.wr(8'h20, 8'h02);
        sample(1'b0, 10'h155, 10'h0aa, 10'h3c3);
        e = exp_out(10'h155, o[0], rng);
        rdc(8'h03, e[9:2]);
        rdc(8'h0a, 8'h00);
        sample(1'b1, 10'h001, 10'h002, 10'h003);
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1;
        check_bit(event_pin_o, 1'b0);
        check_bit(event_pin_oe_n, 1'b0);
        rdc(8'h0a, 8'h80);
        @(posedge ref_clk);
        #1;
        check_bit(event_pin_o, 1'b1);
        check_bit(event_pin_oe_n, 1'b1);
        // Suspend drops offset writes and samples, power writes still land
        u_host.wr(8'h11, 8'h80);
        u_host.wr(8'h38, 8'h55);
        sample(1'b1, 10'h004, 10'h005, 10'h006);
        rdc(8'h38, o[0]);
        rdc(8'h0a, 8'h00);
        rdc(8'h11, 8'h80);
        u_host.wr(8'h11, 8'h00);
        rdc(8'h11, 8'h00);
        u_host.wr(8'h0f, 8'h08);
        u_host.wr(8'h14, 8'h5a);
        rdc(8'h0f, 8'h03);
        rdc(8'h38, 8'h00);
        rdc(8'h20, 8'h01);
        check_bit(wdt_en, 1'b0);
        print_verdict();
    end
endmodule
